// ==== rtl/eid_top.v ====
// external request detect and hold controller with apb registers
// Notes on behaviour
// - eight request pins, each edge or level
// - sense 00 or 01 edge sets flag
// - sense 10 or 11 selects level sensing
// - flag bit 7 is request 0
// - edge flag clears by zero after read-one
// - writing one to edge flag ignored
// - hold set: flag tracks pin, writes ignored
// - hold set: flag drops when pin negates
// - hold set: no internal latching
// - hold clear: level request latched in flag
// - latched flag clears on accept or mask once pin negates
// - non-maskable pin edge polarity selectable
//
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "eid_defines.vh"

module eid_top #(
    parameter NREQ = 8
) (
    input wire i_clock, // 50 mhz system clock
    input wire i_rst_b, // async reset, active low
    input wire [11:0] i_paddr, // apb byte address
    input wire i_psel, // apb select
    input wire i_penable, // apb access phase
    input wire i_pwrite, // apb write
    input wire [31:0] i_pwdata, // apb write data
    output reg [31:0] o_prdata, // apb read data
    output reg o_pready, // apb ready
    output reg o_pslverr, // apb error
    input wire [NREQ-1:0] i_ext_req_pin, // request pins, bit n = pin n
    input wire i_nmi_pin, // non-maskable request pin
    input wire i_core_accept, // core accepted any interrupt
    input wire i_core_accept_nmi, // core accepted the nmi
    output reg [NREQ-1:0] o_ext_req, // unmasked requests to core
    output reg o_nmi_req, // nmi pending to core
    output reg [3:0] o_core_mask_level, // core mask level
    output reg o_irq // summary interrupt, level
);

// ----------------------------------------------------------------
// registers and pin synchronisation
// ----------------------------------------------------------------
reg [NREQ-1:0] flags; // internal order: bit n = pin n
reg [NREQ-1:0] read_one; // edge flags seen as one by software
reg [NREQ-1:0] irq_mask_bits;
reg [2:0] intr_ctrl_reg_zero;
reg [2*NREQ-1:0] intr_ctrl_reg_one;
reg [1:0] istat;
reg [1:0] core_mask_level;
wire [NREQ:0] pins_sync;
wire [NREQ:0] rise;
wire [NREQ:0] fall;
// control fields read across the block
wire level_hold_ctrl = intr_ctrl_reg_zero[`EID_C0_HOLD];
wire nonmaskable_edge_select = intr_ctrl_reg_zero[`EID_C0_NMI_EDGE];
wire mask_auto_update = intr_ctrl_reg_zero[`EID_C0_MU];

// pins pass two flops before any detection
eid_sync #(.WIDTH(NREQ+1)) u_sync (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_async({i_nmi_pin, i_ext_req_pin}),
    .o_sync(pins_sync)
);

// rise and fall pulses from the synchronised levels
eid_edge #(.WIDTH(NREQ+1)) u_edge (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_level(pins_sync),
    .o_rise(rise),
    .o_fall(fall)
);

// ----------------------------------------------------------------
// apb decode
// ----------------------------------------------------------------
// a transfer is taken once, in its first access cycle; the ready
// that follows blocks a second take of the same transfer
wire acc = i_psel & i_penable & ~o_pready;
wire wr = acc & i_pwrite;
wire rd = acc & ~i_pwrite;
// one word per register; any other address answers with an error
// and reads zero, so a stray access can never change state
wire hit_flags = (i_paddr == `EID_OFF_FLAGS);
wire hit_mask = (i_paddr == `EID_OFF_MASK);
wire hit_c0 = (i_paddr == `EID_OFF_CTRL0);
wire hit_c1 = (i_paddr == `EID_OFF_CTRL1);
wire hit_is = (i_paddr == `EID_OFF_ISTAT);
wire hit_im = (i_paddr == `EID_OFF_CORE_MASK_LEVEL);
wire hit_core = (i_paddr == `EID_OFF_CORE);
wire mapped = hit_flags | hit_mask | hit_c0 | hit_c1 | hit_is | hit_im
    | hit_core;

// flag register seen by software, request 0 in bit 7
reg [NREQ-1:0] flags_sw;
reg [NREQ-1:0] wdata_int; // write data in internal order
integer k;
always @* begin
    flags_sw = {NREQ{1'b0}};
    wdata_int = {NREQ{1'b0}};
    for (k = 0; k < NREQ; k = k + 1) begin
        flags_sw[NREQ-1-k] = flags[k];
        wdata_int[k] = i_pwdata[NREQ-1-k];
    end
end

// ----------------------------------------------------------------
// per-pin flag logic
// ----------------------------------------------------------------
// each pin has its own mode; no state is shared between pins
genvar g;
generate
    for (g = 0; g < NREQ; g = g + 1) begin : g_pin
        wire [1:0] pin_sense_select = intr_ctrl_reg_one[2*g+1:2*g];
        // upper select bit picks level sensing
        wire lvl = pin_sense_select[`EID_SENSE_LEVEL_BIT];
        wire pin = pins_sync[g];
        // zero write clears only after the flag was read as one
        wire sw_clr = wr & hit_flags & ~wdata_int[g] & read_one[g];
        reg next_flag;
        reg next_read;
        always @* begin
            next_flag = flags[g];
            next_read = read_one[g];
            if (!lvl) begin
                // edge sensing; set wins over a same-cycle clear
                if (sw_clr) begin
                    next_flag = 1'b0;
                    next_read = 1'b0;
                end
                if (rd & hit_flags & flags[g]) begin
                    next_read = 1'b1;
                end
                if (rise[g]) begin
                    next_flag = 1'b1;
                end
            end else if (level_hold_ctrl) begin
                // pure tracking, writes have no effect
                next_flag = pin;
                next_read = 1'b0;
            end else begin
                next_read = 1'b0;
                // latched until pin gone and accept or mask
                if (!pin & (i_core_accept | irq_mask_bits[g])) begin
                    next_flag = 1'b0;
                end
                if (pin) begin
                    next_flag = 1'b1;
                end
            end
        end
        always @(posedge i_clock or negedge i_rst_b) begin
            if (!i_rst_b) begin
                flags[g] <= 1'b0;
                read_one[g] <= 1'b0;
            end else begin
                flags[g] <= next_flag;
                read_one[g] <= next_read;
            end
        end
    end
endgenerate

// ----------------------------------------------------------------
// non-maskable request and core mask level
// ----------------------------------------------------------------
// polarity chosen by edge select: 1 rising, 0 falling
wire nmi_edge = nonmaskable_edge_select ? rise[NREQ] : fall[NREQ];
// new request: an unmasked flag not yet shown to the core
wire any_req_rise = |(flags & ~irq_mask_bits & ~o_ext_req);

// pending non-maskable request
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_nmi_req <= 1'b0;
    end else begin
        // set wins so an edge in the accept cycle is not lost
        if (nmi_edge) begin
            o_nmi_req <= 1'b1;
        end else if (i_core_accept_nmi) begin
            o_nmi_req <= 1'b0;
        end
    end
end

// core mask level: forced on accepted nmi when mask update is set, else software writes
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_core_mask_level <= `EID_RST_LEVEL;
    end else begin
        // the forced level wins over a write in the same cycle
        if (i_core_accept_nmi & mask_auto_update) begin
            o_core_mask_level <= `EID_MASK_LEVEL_MAX;
        end else if (wr & hit_core) begin
            o_core_mask_level <= i_pwdata[3:0];
        end
    end
end

// ----------------------------------------------------------------
// software registers
// ----------------------------------------------------------------
// pin mask, reset all masked so no stray request reaches the core
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        irq_mask_bits <= `EID_RST_MASK;
    end else if (wr & hit_mask) begin
        irq_mask_bits <= i_pwdata[NREQ-1:0];
    end
end

// control zero: hold, nmi polarity, mask update
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        intr_ctrl_reg_zero <= `EID_RST_CTRL0;
    end else if (wr & hit_c0) begin
        intr_ctrl_reg_zero <= i_pwdata[2:0];
    end
end

// control one: two sense bits per pin, reset to edge sensing
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        intr_ctrl_reg_one <= `EID_RST_CTRL1;
    end else if (wr & hit_c1) begin
        intr_ctrl_reg_one <= i_pwdata[2*NREQ-1:0];
    end
end

// event enables for the summary interrupt
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        core_mask_level <= `EID_RST_CORE_MASK_LEVEL;
    end else if (wr & hit_im) begin
        core_mask_level <= i_pwdata[1:0];
    end
end

// ----------------------------------------------------------------
// interrupt status and outputs to the core
// ----------------------------------------------------------------
// status events: new unmasked request, selected nmi edge
wire [1:0] istat_set = {nmi_edge, any_req_rise};
// write one clears; bits written as zero are left alone
wire [1:0] istat_clr = (wr & hit_is) ? i_pwdata[1:0] : 2'h0;

// sticky status; a new event in the clear cycle still sets
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        istat <= `EID_RST_ISTAT;
    end else begin
        istat <= (istat & ~istat_clr) | istat_set;
    end
end

// registered outputs to the core, one cycle behind the state
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_ext_req <= {NREQ{1'b0}};
        o_irq <= 1'b0;
    end else begin
        o_ext_req <= flags & ~irq_mask_bits;
        o_irq <= |(istat & core_mask_level);
    end
end

// ----------------------------------------------------------------
// bus answer
// ----------------------------------------------------------------
// one wait state: ready answers the cycle after access; read data
// is zero outside the answer so stale values never leak
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        o_pready <= 1'b0;
        o_pslverr <= 1'b0;
        o_prdata <= 32'h0;
    end else begin
        o_pready <= acc;
        o_pslverr <= acc & ~mapped;
        o_prdata <= 32'h0;
        if (rd) begin
            case (1'b1)
                hit_flags: o_prdata <= {24'h0, flags_sw};
                hit_mask: o_prdata <= {24'h0, irq_mask_bits};
                hit_c0: o_prdata <= {28'h0, pins_sync[NREQ],
                    intr_ctrl_reg_zero};
                hit_c1: o_prdata <= {16'h0, intr_ctrl_reg_one};
                hit_is: o_prdata <= {30'h0, istat};
                hit_im: o_prdata <= {30'h0, core_mask_level};
                hit_core: o_prdata <= {28'h0, o_core_mask_level};
                default: o_prdata <= 32'h0;
            endcase
        end
    end
end

endmodule // eid_top
`default_nettype wire

// ==== rtl/eid_defines.vh ====
// constants for the external request detect and hold block
`ifndef EID_DEFINES_VH
`define EID_DEFINES_VH

// register byte offsets on the apb bus
`define EID_OFF_FLAGS 12'h000
`define EID_OFF_MASK 12'h004
`define EID_OFF_CTRL0 12'h008
`define EID_OFF_CTRL1 12'h00c
`define EID_OFF_ISTAT 12'h010
`define EID_OFF_CORE_MASK_LEVEL 12'h014
`define EID_OFF_CORE 12'h018

// control register zero field positions
`define EID_C0_HOLD 0
`define EID_C0_NMI_EDGE 1
`define EID_C0_MU 2

// sense select: upper bit set means level sensing
`define EID_SENSE_LEVEL_BIT 1

// core mask level forced on non-maskable acceptance
`define EID_MASK_LEVEL_MAX 4'hf

// reset values
`define EID_RST_FLAGS 8'h00
`define EID_RST_MASK 8'hff
`define EID_RST_CTRL1 16'h0000
`define EID_RST_CTRL0 3'h0
`define EID_RST_CORE_MASK_LEVEL 2'h0
`define EID_RST_ISTAT 2'h0
`define EID_RST_LEVEL 4'h0

// interrupt status bit positions
`define EID_IS_REQ 0
`define EID_IS_NMI 1

`endif

// ==== rtl/eid_sync.v ====
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
`default_nettype none

module eid_sync #(
    parameter WIDTH = 9
) (
    input wire i_clock, // system clock
    input wire i_rst_b, // async reset, active low
    input wire [WIDTH-1:0] i_async, // raw pin levels
    output reg [WIDTH-1:0] o_sync // synchronised levels
);

reg [WIDTH-1:0] meta;

// first stage feeds only the second
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        meta <= {WIDTH{1'b0}};
        o_sync <= {WIDTH{1'b0}};
    end else begin
        meta <= i_async;
        o_sync <= meta;
    end
end

endmodule // eid_sync
`default_nettype wire

// ==== rtl/eid_edge.v ====
// per-bit edge detector on synchronised levels
`timescale 1ns/1ps
`default_nettype none

module eid_edge #(
    parameter WIDTH = 9
) (
    input wire i_clock, // system clock
    input wire i_rst_b, // async reset, active low
    input wire [WIDTH-1:0] i_level, // synchronised levels
    output wire [WIDTH-1:0] o_rise, // rising edge pulse
    output wire [WIDTH-1:0] o_fall // falling edge pulse
);

reg [WIDTH-1:0] last;

// previous level, reset low so a pin high at reset gives one rise
always @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
        last <= {WIDTH{1'b0}};
    end else begin
        last <= i_level;
    end
end

assign o_rise = i_level & ~last;
assign o_fall = ~i_level & last;

endmodule // eid_edge
`default_nettype wire

// ==== verif/eid_top_assertions.sv ====
// port checker for the request controller
`timescale 1ns/1ps
`default_nettype none
module eid_top_assertions (
    input wire logic i_clock, // clock
    input wire logic i_rst_b, // reset, low
    input wire logic [11:0] i_paddr, // address
    input wire logic i_psel, // select
    input wire logic i_penable, // access
    input wire logic i_pwrite, // write
    input wire logic [31:0] i_pwdata, // write data
    input wire logic [31:0] o_prdata, // read data
    input wire logic o_pready, // ready
    input wire logic o_pslverr, // error
    input wire logic i_core_accept_nmi, // nmi accept
    input wire logic o_nmi_req, // nmi pending
    input wire logic [3:0] o_core_mask_level // mask level
);
    // ---------------------------------
    // apb timing and core side
    // ---------------------------------
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);
    logic wr_lvl;
    logic mu_seen;
    // shadow of the mask update bit, from writes to control zero
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            mu_seen <= 1'b0;
        end else if (i_psel && i_penable && i_pwrite && !o_pready
            && i_paddr == 12'h008) begin
            mu_seen <= i_pwdata[2];
        end
    end
    // level may move only from its own write or an accepted nmi
    assign wr_lvl = i_psel & i_penable & i_pwrite & ~o_pready
        & (i_paddr == 12'h018);
    sequence s_taken;
        i_psel && i_penable && !o_pready;
    endsequence
    sequence s_answer;
        o_pready ##1 !o_pready;
    endsequence
    a_ready_one_wait: assert property (s_taken |=> s_answer)
        else $error("pready not one cycle after access");
    a_ready_has_cause: assert property (o_pready |-> $past(i_psel))
        else $error("pready without request");
    a_err_with_ready: assert property (o_pslverr |-> o_pready)
        else $error("pslverr outside answer");
    a_rdata_idle_zero: assert property (!o_pready |-> o_prdata == 0)
        else $error("read data not zero when idle");
    a_nmi_clear_cause: assert property (
        $fell(o_nmi_req) |-> $past(i_core_accept_nmi))
        else $error("nmi request dropped without accept");
    a_level_forced: assert property (
        i_core_accept_nmi && mu_seen |=> o_core_mask_level == 4'hf)
        else $error("mask level not forced to fifteen");
    a_level_cause: assert property (
        $changed(o_core_mask_level) |-> $past(i_core_accept_nmi)
        || $past(wr_lvl) || $past(wr_lvl, 2))
        else $error("mask level changed without cause");
endmodule // eid_top_assertions
bind eid_top eid_top_assertions chk_u (.i_clock, .i_rst_b, .i_paddr,
    .i_psel, .i_penable, .i_pwrite, .i_pwdata, .o_prdata, .o_pready,
    .o_pslverr,
    .i_core_accept_nmi, .o_nmi_req, .o_core_mask_level);
`default_nettype wire

// ==== verif/eid_req_src.sv ====
// model of the external requesters on the pins
`timescale 1ns/1ps
`default_nettype none
module eid_req_src (
    input wire logic i_clock, // clock
    input wire logic [7:0] i_want, // wanted pin levels
    input wire logic i_want_nmi, // wanted nmi level
    output logic [7:0] o_pin, // request pins
    output logic o_nmi // nmi pin
);
    // pins idle low until first command
    initial begin
        o_pin = 8'h00;
        o_nmi = 1'b0;
    end
    // pins move off the edge: truly async
    always @(posedge i_clock) begin
        o_pin <= #7 i_want;
        o_nmi <= #7 i_want_nmi;
    end
endmodule // eid_req_src
`default_nettype wire

// ==== verif/tb_eid_top.sv ====
// self-checking bench for the request controller
`timescale 1ns/1ps
`default_nettype none
module tb_eid_top;
    logic i_clock, i_rst_b, psel, pen, pwr, acc, acc_nmi, want_nmi;
    logic pready, perr, nmi_pin, nmi_req, irq, rerr;
    logic [11:0] addr;
    logic [31:0] wdat, rd, prdata;
    logic [7:0] want, pins, ext_req;
    logic [3:0] lvl;
    int err_count, n_compared, cyc;
    eid_top dut_u (.i_clock, .i_rst_b, .i_paddr(addr), .i_psel(psel),
        .i_penable(pen), .i_pwrite(pwr), .i_pwdata(wdat),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(perr),
        .i_ext_req_pin(pins), .i_nmi_pin(nmi_pin), .i_core_accept(acc),
        .i_core_accept_nmi(acc_nmi), .o_ext_req(ext_req),
        .o_nmi_req(nmi_req), .o_core_mask_level(lvl), .o_irq(irq));
    eid_req_src src_u (.i_clock, .i_want(want), .i_want_nmi(want_nmi),
        .o_pin(pins), .o_nmi(nmi_pin));
    // -------------------------------
    // clock, timeout and tasks
    // -------------------------------
    initial begin
        i_clock = 1'b0;
        forever #10 i_clock = ~i_clock;
    end
    // cut a hang short well past the run length
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            give_verdict;
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    // one apb transfer, entered just after an edge
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdat <= d;
        @(posedge i_clock) pen <= 1'b1;
        @(posedge i_clock);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge i_clock);
            n++;
        end
        rd = prdata;
        rerr = perr;
        if (n >= 20) chk("pready", 1, 0);
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge i_clock);
    endtask
    task automatic rc(input string nm, input logic [11:0] a,
        input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    // pulse one core accept line for a cycle
    task automatic pulse(input logic nmi);
        if (nmi) acc_nmi <= 1'b1;
        else acc <= 1'b1;
        @(posedge i_clock);
        acc <= 1'b0;
        acc_nmi <= 1'b0;
        repeat (2) @(posedge i_clock);
    endtask
    // pins need sync and detect time
    task automatic settle;
        repeat (6) @(posedge i_clock);
    endtask
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // -------------------------------
    // main sequence
    // -------------------------------
    initial begin
        {i_rst_b, psel, pen, pwr, acc, acc_nmi, want_nmi} = 7'h0;
        {addr, wdat, want} = 52'h0;
        {err_count, n_compared, cyc} = 0;
        repeat (12) @(posedge i_clock);
        i_rst_b <= 1'b1;
        @(posedge i_clock);
        rc("flags rst", 12'h000, 32'h0);
        rc("ctrl0 rst", 12'h008, 32'h0);
        rc("ctrl1 rst", 12'h00c, 32'h0);
        rc("unmapped", 12'hffc, 32'h0);
        chk("slverr", 1, rerr);
        xfer(1'b1, 12'h004, 32'h0);
        xfer(1'b1, 12'h014, 32'h1);
        want <= 8'h01;
        settle;
        rc("edge flag", 12'h000, 32'h80);
        chk("ext req", 8'h01, ext_req);
        chk("irq on", 1, irq);
        xfer(1'b1, 12'h014, 32'h0);
        chk("irq masked", 0, irq);
        xfer(1'b1, 12'h010, 32'h1);
        xfer(1'b1, 12'h014, 32'h1);
        chk("irq clear", 0, irq);
        xfer(1'b1, 12'h00c, 32'h4);
        want <= 8'h03;
        settle;
        xfer(1'b1, 12'h000, 32'h3f);
        rc("clr unread", 12'h000, 32'h40);
        xfer(1'b1, 12'h000, 32'hff);
        rc("write one", 12'h000, 32'h40);
        xfer(1'b1, 12'h000, 32'hbf);
        rc("clr read", 12'h000, 32'h0);
        // level sensing with hold on, pin 2
        want <= 8'h00;
        xfer(1'b1, 12'h00c, 32'h20);
        xfer(1'b1, 12'h008, 32'h1);
        want <= 8'h04;
        settle;
        rc("hold track", 12'h000, 32'h20);
        xfer(1'b1, 12'h000, 32'h0);
        rc("hold write", 12'h000, 32'h20);
        want <= 8'h00;
        settle;
        rc("hold drop", 12'h000, 32'h0);
        // hold off: request latched
        xfer(1'b1, 12'h00c, 32'h30);
        xfer(1'b1, 12'h008, 32'h0);
        want <= 8'h04;
        settle;
        want <= 8'h00;
        settle;
        rc("latched", 12'h000, 32'h20);
        pulse(1'b0);
        rc("accept clr", 12'h000, 32'h0);
        want <= 8'h04;
        settle;
        want <= 8'h00;
        settle;
        xfer(1'b1, 12'h004, 32'hff);
        rc("mask clr", 12'h000, 32'h0);
        // nmi on both polarities, mask update
        xfer(1'b1, 12'h008, 32'h6);
        want_nmi <= 1'b1;
        settle;
        chk("nmi rise", 1, nmi_req);
        rc("nmi level", 12'h008, 32'he);
        pulse(1'b1);
        chk("level 15", 4'hf, lvl);
        chk("nmi clr", 0, nmi_req);
        xfer(1'b1, 12'h008, 32'h0);
        xfer(1'b1, 12'h018, 32'h3);
        want_nmi <= 1'b0;
        settle;
        chk("nmi fall", 1, nmi_req);
        pulse(1'b1);
        chk("level kept", 4'h3, lvl);
        rc("level reg", 12'h018, 32'h3);
        give_verdict;
    end
endmodule // tb_eid_top
`default_nettype wire
